// ---- pkg/snr_pkg.sv ----
// shared constants for the serial-number read path
`default_nettype none
package snr_pkg;
   localparam logic [7:0] SNR_READ_SERIAL_NUMBER_CMD = 8'h81;
   localparam int SNR_ADDR_BYTES = 2;
   localparam int SNR_HDR_BITS = 8 + 8 * SNR_ADDR_BYTES;
   localparam logic [4:0] SNR_HDR_LAST = 5'(SNR_HDR_BITS - 1);
   localparam int SNR_BYTE_W = 8;
   localparam int SNR_FIFO_DEPTH = 8;
   localparam int SNR_BLOCK_BYTES = 16;
   localparam int SNR_PTR_W = 4;
   localparam int SNR_BUSY_BIT = 0;
   localparam logic [7:0] SNR_STATUS_RST = 8'h00;
   localparam logic [3:0] SNR_PTR_RST = 4'h0;
   localparam logic [4:0] SNR_BITC_RST = 5'h00;
   // arbitrary neutral factory value, no meaning
   localparam logic [127:0] SNR_SERIAL_DEFAULT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

   typedef enum logic [1:0] {
      SNR_IDLE,
      SNR_HDR,
      SNR_DATA,
      SNR_SKIP
   } snr_state_t;
endpackage : snr_pkg
`default_nettype wire

// ---- core/snr_byte_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
// small synchronous fifo with flush; full and empty come from the count
module snr_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
   } snr_fifo_st_t;

   snr_fifo_st_t s;
   snr_fifo_st_t next_s;
   logic push;
   logic pop;

   assign in_ready = (s.count != (AW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = s.mem[s.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count update; flush wins so a new frame starts empty
   always_comb begin
      next_s = s;
      if (flush) begin
         next_s.wp = '0;
         next_s.rp = '0;
         next_s.count = '0;
      end else begin
         if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
         end
         if (pop) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
         end
         next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : snr_byte_fifo
`default_nettype wire

// ---- core/snr_serial_number_read_path.sv ----
`timescale 1ns/1ns
`default_nettype none
module snr_serial_number_read_path
   import snr_pkg::*;
#(
   parameter logic [127:0] FACTORY_SERIAL_BLOCK = SNR_SERIAL_DEFAULT
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // write engine state and status byte
   input wire logic write_busy_flag,
   output logic [7:0] status_byte
);
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic sclk_m;
      logic sclk_s;
      logic sclk_d;
      logic mosi_m;
      logic mosi_s;
      snr_state_t st;
      logic [22:0] hdr;
      logic [4:0] bitc;
      logic [3:0] fptr;
      logic fetch_on;
      logic [7:0] obyte;
      logic miso;
      logic oe;
      logic [7:0] status;
   } snr_st_t;

   snr_st_t s;
   snr_st_t next_s;
   logic rise;
   logic fall;
   logic hdr_done;
   logic cmd_ok;
   logic load;
   logic f_in_ready;
   logic f_out_valid;
   logic [7:0] f_out_data;
   logic f_flush;

   // byte n of the block sits at the top end for n = 0
   function automatic logic [7:0] sn_byte(input logic [3:0] idx);
      sn_byte = FACTORY_SERIAL_BLOCK[8'd127 - {1'b0, idx, 3'b000} -: 8];
   endfunction : sn_byte

   // edges seen on the synchronised clock, never on the first flop
   assign rise = s.sclk_s && !s.sclk_d;
   assign fall = !s.sclk_s && s.sclk_d;
   assign hdr_done = (s.st == SNR_HDR) && rise && (s.bitc == SNR_HDR_LAST);
   assign cmd_ok = (s.hdr[22:15] == SNR_READ_SERIAL_NUMBER_CMD);
   assign load = (s.st == SNR_DATA) && fall && (s.bitc[2:0] == 3'h0);
   assign f_flush = s.cs_s;

   // prefetch buffer decouples the block read from the link timing
   snr_byte_fifo #(
      .WIDTH(SNR_BYTE_W),
      .DEPTH(SNR_FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .flush(f_flush),
      .in_valid(s.fetch_on),
      .in_ready(f_in_ready),
      .in_data(sn_byte(s.fptr)),
      .out_valid(f_out_valid),
      .out_ready(load),
      .out_data(f_out_data)
   );

   // whole next state; select high overrides state, fetch, pin and bit count
   always_comb begin
      next_s = s;
      next_s.cs_m = cs_n;
      next_s.cs_s = s.cs_m;
      next_s.sclk_m = sclk;
      next_s.sclk_s = s.sclk_m;
      next_s.sclk_d = s.sclk_s;
      next_s.mosi_m = mosi;
      next_s.mosi_s = s.mosi_m;
      next_s.status = SNR_STATUS_RST;
      next_s.status[SNR_BUSY_BIT] = write_busy_flag;
      // block is only ever read; the fifo push is the sole consumer
      if (s.fetch_on && f_in_ready) begin
         next_s.fptr = s.fptr + 4'h1; // 4-bit pointer wraps 15 to 0
      end
      case (s.st)
         SNR_IDLE: begin
            next_s.bitc = SNR_BITC_RST;
            if (!s.cs_s) begin
               next_s.st = SNR_HDR;
            end
         end
         SNR_HDR: begin
            if (rise) begin
               next_s.hdr = {s.hdr[21:0], s.mosi_s};
               next_s.bitc = s.bitc + 5'h01;
            end
            if (hdr_done) begin
               next_s.bitc = SNR_BITC_RST;
               if (cmd_ok && !write_busy_flag) begin
                  next_s.st = SNR_DATA;
                  next_s.fptr = {s.hdr[2:0], s.mosi_s}; // upper bits ignored
                  next_s.fetch_on = 1'b1;
               end else begin
                  next_s.st = SNR_SKIP;
               end
            end
         end
         SNR_DATA: begin
            // data changes on the falling edge so the host samples on rise
            if (fall) begin
               next_s.bitc = {2'b00, s.bitc[2:0] + 3'h1};
               next_s.oe = 1'b1;
               if (load) begin
                  next_s.miso = f_out_data[7]; // msb first
                  next_s.obyte = {f_out_data[6:0], 1'b0};
               end else begin
                  next_s.miso = s.obyte[7];
                  next_s.obyte = {s.obyte[6:0], 1'b0};
               end
            end
         end
         SNR_SKIP: begin
            next_s.oe = 1'b0;
         end
         default: begin
            next_s.st = SNR_IDLE;
         end
      endcase
      // deselect aborts at any bit and releases the pin
      if (s.cs_s) begin
         next_s.st = SNR_IDLE;
         next_s.fetch_on = 1'b0;
         next_s.oe = 1'b0;
         next_s.miso = 1'b0;
         next_s.bitc = SNR_BITC_RST;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.cs_m <= 1'b1;
         s.cs_s <= 1'b1;
         s.st <= SNR_IDLE;
         s.fptr <= SNR_PTR_RST;
         s.status <= SNR_STATUS_RST;
      end else begin
         s <= next_s;
      end
   end

   assign miso = s.miso;
   assign miso_oe = s.oe;
   assign status_byte = s.status;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // a deselect in the header's last cycle wins, so these judge only frames still selected
   AST_CMD_ACCEPT: assert property (hdr_done && cmd_ok && !write_busy_flag && !s.cs_s
      |=> s.st == SNR_DATA && s.fetch_on) else $error("read command not accepted");
   AST_BUSY_REJECT: assert property (hdr_done && write_busy_flag && !s.cs_s
      |=> s.st == SNR_SKIP && !s.fetch_on) else $error("command taken while busy");
   AST_ADDR_LOW: assert property (hdr_done && cmd_ok && !write_busy_flag && !s.cs_s
      |=> s.fptr == $past({s.hdr[2:0], s.mosi_s})) else $error("wrong start byte");
   AST_MSB_LOAD: assert property (load && f_out_valid && !s.cs_s |=>
      s.miso == $past(f_out_data[7]) && s.oe) else $error("byte msb not driven");
   AST_SHIFT: assert property ((s.st == SNR_DATA) && fall && !load && !s.cs_s |=>
      s.miso == $past(s.obyte[7])) else $error("bit order broken");
   AST_PTR_STEP: assert property (s.fetch_on && f_in_ready && !s.cs_s |=>
      s.fptr == $past(s.fptr) + 4'h1) else $error("pointer did not advance");
   AST_WRAP: assert property (s.fetch_on && f_in_ready && s.fptr == 4'hf && !s.cs_s |=>
      s.fptr == 4'h0) else $error("pointer did not wrap");
   AST_DESELECT: assert property (s.cs_s |=> s.st == SNR_IDLE ##1 !miso_oe)
      else $error("deselect did not end the read");
   AST_HIZ: assert property (s.st != SNR_DATA |=> !miso_oe)
      else $error("pin driven outside data phase");
   AST_STATUS: assert property (write_busy_flag |=> status_byte == 8'h01)
      else $error("busy not reported");
   // pin, prefetch and status checks; the prefetch must never run dry at a byte edge
   AST_STATUS_CLEAR: assert property (!write_busy_flag |=> status_byte == 8'h00)
      else $error("busy shown after the write ended");
   AST_NO_UNDERRUN: assert property (load && !s.cs_s |-> f_out_valid)
      else $error("next byte not buffered at the byte edge");
   AST_DATA_DRIVE: assert property ((s.st == SNR_DATA) && fall && !s.cs_s |=> miso_oe)
      else $error("data bit not driven");
   AST_SKIP_QUIET: assert property (s.st == SNR_SKIP && !s.cs_s |=>
      s.st == SNR_SKIP && !miso_oe) else $error("refused frame went on");
   AST_PIN_LOW: assert property (s.cs_s |=> !miso && !s.fetch_on)
      else $error("pin or prefetch left active after deselect");

   // main scenarios: a read, a busy refusal, a wrap and a cut byte
   COV_READ: cover property (hdr_done && cmd_ok && !write_busy_flag);
   COV_BUSY: cover property (hdr_done && cmd_ok && write_busy_flag);
   COV_WRAP: cover property (s.fetch_on && f_in_ready && s.fptr == 4'hf);
   COV_ABORT: cover property ((s.st == SNR_DATA) && s.bitc[2:0] == 3'h4 && s.cs_s);
endmodule : snr_serial_number_read_path
`default_nettype wire

// ---- testbench/snr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// link host, mode 0; sclk stands low between frames
module snr_host_model (
   // pacing clock
   input wire logic clock,
   // link pins
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso_line,
   input wire logic miso_oe,
   // results, toggle marks a new word
   output logic rx_stb,
   output logic [8:0] rx_word
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      rx_stb = 1'b0;
      rx_word = 9'h000;
   end
   task automatic half();
      repeat (4) @(negedge clock);
   endtask : half
   // sample late in the high phase: the device drives 2-3 clocks after the fall
   task automatic bit_io(input logic b, output logic q, output logic oe);
      mosi = b;
      half();
      sclk = 1'b1;
      half();
      q = miso_line;
      oe = miso_oe;
      sclk = 1'b0;
   endtask : bit_io
   task automatic report(input logic [8:0] w);
      rx_word = w;
      rx_stb = ~rx_stb;
   endtask : report
   // header msb first, then nbits clocks; a partial byte is dropped
   task automatic frame(input logic [23:0] hdr, input int nbits, input logic [31:0] fill);
      logic q, oe, hoe, all;
      logic [7:0] sh;
      hoe = 1'b0;
      all = 1'b1;
      sh = 8'h00;
      cs_n = 1'b0;
      half();
      for (int i = 23; i >= 0; i--) begin
         bit_io(hdr[i], q, oe);
         hoe |= oe;
      end
      report({hoe, 8'h00});
      for (int i = 0; i < nbits; i++) begin
         bit_io(fill[i % 32], q, oe);
         sh = {sh[6:0], q};
         all &= oe;
         if (i % 8 == 7) begin
            report({all, sh});
            all = 1'b1;
         end
      end
      half();
      cs_n = 1'b1;
      mosi = ~mosi; // released line, show no stale value
      repeat (16) @(negedge clock);
   endtask : frame
endmodule : snr_host_model
`default_nettype wire

// ---- testbench/test_serial_number_read_path.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_serial_number_read_path;
   import snr_pkg::*;
   // arbitrary serial value
   localparam logic [127:0] SER = 128'h5a3c_e1f0_0f1e_2d3c_4b5a_6978_8796_a5b4;
   logic clock, rstn, write_busy_flag, miso, miso_oe, cs_n, sclk, mosi, rx_stb;
   logic [7:0] status_byte;
   logic [8:0] rx_word;
   logic [31:0] rs = 32'h0000_005e;
   logic [8:0] exp_q[$];
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   // pull-up keeps the undriven line at one
   tri1 miso_line;
   assign miso_line = miso_oe ? miso : 1'bz;
   snr_serial_number_read_path #(.FACTORY_SERIAL_BLOCK(SER)) u_dut (.clock(clock), .rstn(rstn),
      .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .write_busy_flag(write_busy_flag), .status_byte(status_byte));
   snr_host_model u_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
      .miso_line(miso_line), .miso_oe(miso_oe), .rx_stb(rx_stb), .rx_word(rx_word));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   task automatic cmp(string what, logic [8:0] e, logic [8:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic cmp_status(logic [7:0] e);
      checks_done++;
      if (status_byte !== e) begin
         error_cnt++;
         $display("Error status expected %h seen %h", e, status_byte);
      end
   endtask : cmp_status
   // header word first, then {oe, byte} per byte
   task automatic rd(logic [3:0] a, int n, int extra);
      logic [31:0] r;
      r = rnd();
      exp_q.push_back(9'h000);
      for (int k = 0; k < n; k++)
         exp_q.push_back({1'b1, SER[127 - 8 * ((a + k) % 16) -: 8]});
      u_host.frame({SNR_READ_SERIAL_NUMBER_CMD, r[15:4], a}, 8 * n + extra, rnd());
   endtask : rd
   // refused frame: line stays undriven
   task automatic ign(logic [7:0] op, int n);
      logic [31:0] r;
      r = rnd();
      exp_q.push_back(9'h000);
      repeat (n) exp_q.push_back(9'h0ff);
      u_host.frame({op, r[15:0]}, 8 * n, rnd());
   endtask : ign
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // watcher takes the oldest note on every result
   always @(rx_stb) begin
      if ($time > 0)
         cmp("word", exp_q.size() > 0 ? exp_q.pop_front() : 9'h1aa, rx_word);
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      rstn = 1'b0;
      write_busy_flag = 1'b0;
      repeat (8) @(negedge clock);
      rstn = 1'b1;
      repeat (4) @(negedge clock);
      cmp_status(SNR_STATUS_RST);
      rd(4'h0, 17, 0);
      rd(4'hf, 2, 0);
      rd(4'h3, 1, 3);
      ign(8'h02, 2);
      ign(8'h83, 1);
      rd(4'h3, 2, 0);
      write_busy_flag = 1'b1;
      repeat (2) @(negedge clock);
      cmp_status(8'h01);
      ign(SNR_READ_SERIAL_NUMBER_CMD, 2);
      write_busy_flag = 1'b0;
      repeat (2) @(negedge clock);
      cmp_status(SNR_STATUS_RST);
      // second reset between frames, taken while a write is busy
      write_busy_flag = 1'b1;
      rstn = 1'b0;
      repeat (2) @(negedge clock);
      cmp_status(SNR_STATUS_RST);
      rstn = 1'b1;
      repeat (2) @(negedge clock);
      cmp_status(8'h01);
      write_busy_flag = 1'b0;
      repeat (4) @(negedge clock);
      rd(4'h9, 3, 5);
      cmp("pending", 9'h000, 9'(exp_q.size()));
      end_sim();
   end
endmodule : test_serial_number_read_path
`default_nettype wire
